/* rtl/buck_regs_pkg.sv */
package buck_regs_pkg;
  localparam logic [7:0] SWITCH_CFG_ADDR = 8'h81;
  localparam logic [7:0] ACTIVE_VOLT_ADDR = 8'h82;
  localparam logic [7:0] ALT_VOLT_ADDR = 8'h83;
  localparam logic [7:0] MODE_CTRL_ADDR = 8'h84;

  localparam logic [7:0] SWITCH_CFG_RESET = 8'h40;
  localparam logic [7:0] ACTIVE_VOLT_RESET = 8'h8d;
  localparam logic [7:0] ALT_VOLT_RESET = 8'h07;
  localparam logic [7:0] MODE_CTRL_RESET = 8'h42;

  // writable bit masks; zero bits are reserved read-only
  localparam logic [7:0] SWITCH_CFG_WMASK = 8'hff;
  localparam logic [7:0] ACTIVE_VOLT_WMASK = 8'h9f;
  localparam logic [7:0] ALT_VOLT_WMASK = 8'h1f;
  localparam logic [7:0] MODE_CTRL_WMASK = 8'hff;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // switching config fields
  localparam int SWITCH_FREQ_SELECT_LSB = 6;
  localparam int LOAD_PD_EN_BIT = 5;
  localparam int DISCHARGE_DIS_BIT = 4;
  localparam int PD_CODE_LSB = 2;
  localparam int GATE_DRIVE_LSB = 0;
  // voltage fields
  localparam int QUIESCENT_SEL_BIT = 7;
  localparam int VOLT_CODE_LSB = 0;
  localparam int VOLT_CODE_W = 5;
  // mode control fields
  localparam int ON_OVERRIDE_BIT = 7;
  localparam int FACTORY_SEQ_BIT = 6;
  localparam int HOLD_ON_BIT = 5;
  localparam int OFF_SLEEP_BIT = 4;
  localparam int OFF_DEEP_SLEEP_BIT = 2;
  localparam int PEAK_LIMIT_BIT = 1;
  localparam int FORCE_CCM_BIT = 0;

  typedef enum logic [1:0] {
    FREQ_1P5MHZ,
    FREQ_2P0MHZ,
    FREQ_2P5MHZ,
    FREQ_3P3MHZ
  } switch_freq_t;
endpackage : buck_regs_pkg

/* rtl/buck_regulator_config_regs.sv */
`timescale 1ns/100ps
// How it works
// R01: two-bit frequency code picks 1.5, 2.0, 2.5 or 3.3 MHz switching.
// R02: pull-down load applies only while enabled bit set and converter running.
// R03: four-bit pull-down code: low bits here, high bits from another register.
// R04: output discharges through resistor at turn-off unless discharge-disable bit is set.
// R05: two-bit gate-drive code, 00 slowest edges, 11 fastest.
// R06: quiescent select bit chooses 45uA when 0, 250uA when 1.
// R07: active five-bit setpoint gives code times 0.1 V plus 0.5 V.
// R08: alternate five-bit setpoint, same mapping; upper three bits reserved read-only.
// R09: override bit 1 enables converter directly, bypassing the sequencer.
// R10: hold bit keeps converter on after its sequencing input drops.
// R11: sleep bit set turns converter off in Sleep mode.
// R12: deep-sleep bit set turns converter off in Deep Sleep mode.
// R13: peak limit select gives 2.0A when 0, 3.0A when 1.
// R14: forced bit set restricts converter to continuous conduction only.
// R15: software keeps reserved bits at their existing values.
// R16: software leaves the factory sequencing bit unchanged.
// R17: reset loads 0x40, 0x8d, 0x07 and 0x42 into the four registers.
// R18: reserved read-only bits read default, ignore writes; fields change only by writes.
module buck_regulator_config_regs
  import buck_regs_pkg::*;
(
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic [7:0] regAddr,
  input wire logic [7:0] regWrData,
  input wire logic regWrEn,
  input wire logic regRdEn,
  output logic [7:0] regRdData,
  output logic regRdValid,
  input wire logic [1:0] pulldownCodeHigh,
  input wire logic seqEnable,
  input wire logic sleepMode,
  input wire logic deepSleepMode,
  output switch_freq_t switchFreqSelect,
  output logic [1:0] gateDriveStrength,
  output logic [3:0] pulldownCurrentCode,
  output logic loadPulldownOn,
  output logic dischargeOn,
  output logic highQuiescent,
  output logic [4:0] activeVoltageCode,
  output logic [4:0] outputVoltageCode,
  output logic converterEnable,
  output logic peakLimitHigh,
  output logic forceContinuousConduction,
  output logic factorySequenceBit
);

  typedef struct packed {
    logic [7:0] switchCfg;
    logic [7:0] activeVolt;
    logic [7:0] altVolt;
    logic [7:0] modeCtrl;
    logic [7:0] rdData;
    logic rdValid;
    logic [3:0] pdCode;
    logic heldOn;
    logic convOn;
    logic loadOn;
    logic discharge;
  } state_t;

  state_t state_r;
  state_t state_nxt;

  // reserved read-only bits keep their current value whatever is written
  function automatic logic [7:0] mergeWrite(input logic [7:0] oldVal,
                                            input logic [7:0] newVal,
                                            input logic [7:0] wMask);
    mergeWrite = (oldVal & ~wMask) | (newVal & wMask);
  endfunction : mergeWrite

  // one place decides which bytes exist, shared by the write and read paths
  function automatic logic isMapped(input logic [7:0] addr);
    isMapped = 1'b0;
    unique case (addr)
      SWITCH_CFG_ADDR: begin
        isMapped = 1'b1;
      end
      ACTIVE_VOLT_ADDR: begin
        isMapped = 1'b1;
      end
      ALT_VOLT_ADDR: begin
        isMapped = 1'b1;
      end
      MODE_CTRL_ADDR: begin
        isMapped = 1'b1;
      end
      default: begin
        isMapped = 1'b0;
      end
    endcase
  endfunction : isMapped

  // unmapped bytes get an empty mask, so a stray write changes nothing
  function automatic logic [7:0] writeMaskFor(input logic [7:0] addr);
    writeMaskFor = 8'h00;
    unique case (addr)
      SWITCH_CFG_ADDR: begin
        writeMaskFor = SWITCH_CFG_WMASK;
      end
      ACTIVE_VOLT_ADDR: begin
        writeMaskFor = ACTIVE_VOLT_WMASK; // R18
      end
      ALT_VOLT_ADDR: begin
        writeMaskFor = ALT_VOLT_WMASK; // R08
      end
      MODE_CTRL_ADDR: begin
        writeMaskFor = MODE_CTRL_WMASK;
      end
      default: begin
        writeMaskFor = 8'h00;
      end
    endcase
  endfunction : writeMaskFor

  // unmapped reads answer a fixed byte rather than whatever was last read
  function automatic logic [7:0] readByte(input state_t cur, input logic [7:0] addr);
    readByte = UNMAPPED_READ;
    unique case (addr)
      SWITCH_CFG_ADDR: begin
        readByte = cur.switchCfg;
      end
      ACTIVE_VOLT_ADDR: begin
        readByte = cur.activeVolt; // R18
      end
      ALT_VOLT_ADDR: begin
        readByte = cur.altVolt; // R18
      end
      MODE_CTRL_ADDR: begin
        readByte = cur.modeCtrl;
      end
      default: begin
        readByte = UNMAPPED_READ;
      end
    endcase
  endfunction : readByte

  function automatic logic [1:0] twoBitField(input logic [7:0] regVal, input int lsb);
    twoBitField = regVal[lsb +: 2];
  endfunction : twoBitField

  function automatic switch_freq_t freqField(input logic [7:0] cfg);
    freqField = switch_freq_t'(twoBitField(cfg, SWITCH_FREQ_SELECT_LSB));
  endfunction : freqField

  function automatic logic [VOLT_CODE_W-1:0] voltField(input logic [7:0] regVal);
    voltField = regVal[VOLT_CODE_LSB +: VOLT_CODE_W];
  endfunction : voltField

  function automatic logic bitAt(input logic [7:0] regVal, input int pos);
    bitAt = regVal[pos];
  endfunction : bitAt

  // high pair lives in another register, sampled here so outputs stay registered
  function automatic logic [3:0] joinPulldown(input logic [1:0] highPair,
                                              input logic [7:0] cfg);
    joinPulldown = {highPair, twoBitField(cfg, PD_CODE_LSB)}; // R03
  endfunction : joinPulldown

  // either sleep level cuts the rail only when its participation bit is set
  function automatic logic sleepAllows(input logic inSleep,
                                       input logic inDeepSleep,
                                       input logic [7:0] mode);
    logic sleepCut;
    logic deepCut;
    sleepCut = inSleep & mode[OFF_SLEEP_BIT]; // R11
    deepCut = inDeepSleep & mode[OFF_DEEP_SLEEP_BIT]; // R12
    sleepAllows = ~sleepCut & ~deepCut;
  endfunction : sleepAllows

  // hold-on only remembers a sequenced turn-on; clearing the bit releases it
  function automatic logic holdNext(input logic [7:0] mode,
                                    input logic seqOn,
                                    input logic held);
    if (mode[HOLD_ON_BIT]) begin
      holdNext = seqOn | held; // R10
    end else begin
      holdNext = 1'b0; // R10
    end
  endfunction : holdNext

  // override bypasses sequencing, yet sleep gating still applies after it
  function automatic logic demandFor(input logic [7:0] mode,
                                     input logic seqOn,
                                     input logic held);
    if (mode[ON_OVERRIDE_BIT]) begin
      demandFor = 1'b1; // R09
    end else begin
      demandFor = seqOn | held; // R10
    end
  endfunction : demandFor

  function automatic logic loadAllowed(input logic [7:0] cfg,
                                       input logic running);
    if (running) begin
      loadAllowed = cfg[LOAD_PD_EN_BIT]; // R02
    end else begin
      loadAllowed = 1'b0; // R02
    end
  endfunction : loadAllowed

  // resistor held across the whole off period, not only the falling edge
  function automatic logic dischargeWanted(input logic [7:0] cfg,
                                           input logic running);
    if (running) begin
      dischargeWanted = 1'b0; // R04
    end else begin
      dischargeWanted = ~cfg[DISCHARGE_DIS_BIT]; // R04
    end
  endfunction : dischargeWanted

  logic demand;
  logic wrHit;
  logic rdHit;
  logic [7:0] wrMask;

  always_comb begin
    state_nxt = state_r;
    state_nxt.rdValid = 1'b0;
    demand = 1'b0;
    wrMask = writeMaskFor(regAddr);
    wrHit = regWrEn & isMapped(regAddr);
    rdHit = regRdEn & isMapped(regAddr);
    // only the addressed byte moves, and only in its writable bits
    if (wrHit) begin
      unique case (regAddr)
        SWITCH_CFG_ADDR: begin
          state_nxt.switchCfg = mergeWrite(state_r.switchCfg, regWrData, wrMask);
        end
        ACTIVE_VOLT_ADDR: begin
          state_nxt.activeVolt = mergeWrite(state_r.activeVolt, regWrData, wrMask); // R18
        end
        ALT_VOLT_ADDR: begin
          state_nxt.altVolt = mergeWrite(state_r.altVolt, regWrData, wrMask); // R08
        end
        MODE_CTRL_ADDR: begin
          state_nxt.modeCtrl = mergeWrite(state_r.modeCtrl, regWrData, wrMask);
        end
        default: begin
        end
      endcase
    end

    // reads see the old byte, so a same-cycle write is not returned yet
    if (regRdEn) begin
      state_nxt.rdValid = 1'b1; // R18
      if (rdHit) begin
        state_nxt.rdData = readByte(state_r, regAddr); // R18
      end else begin
        state_nxt.rdData = UNMAPPED_READ; // R18
      end
    end

    state_nxt.pdCode = joinPulldown(pulldownCodeHigh, state_r.switchCfg); // R03
    state_nxt.heldOn = holdNext(state_r.modeCtrl, seqEnable, state_r.heldOn); // R10
    demand = demandFor(state_r.modeCtrl, seqEnable, state_r.heldOn); // R09 R10
    // load and discharge follow the same registered enable, never both at once
    state_nxt.convOn = demand & sleepAllows(sleepMode, deepSleepMode, state_r.modeCtrl); // R11 R12
    state_nxt.loadOn = loadAllowed(state_r.switchCfg, state_nxt.convOn); // R02
    state_nxt.discharge = dischargeWanted(state_r.switchCfg, state_nxt.convOn); // R04
  end

  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      // register defaults as after power-up
      state_r.switchCfg <= SWITCH_CFG_RESET; // R17
      state_r.activeVolt <= ACTIVE_VOLT_RESET; // R17
      state_r.altVolt <= ALT_VOLT_RESET; // R17
      state_r.modeCtrl <= MODE_CTRL_RESET; // R17

      // converter held off, output pulled down until reset lifts
      state_r.rdData <= 8'h00;
      state_r.rdValid <= 1'b0;
      state_r.pdCode <= 4'h0;
      state_r.heldOn <= 1'b0;
      state_r.convOn <= 1'b0;
      state_r.loadOn <= 1'b0;
      state_r.discharge <= 1'b1;
    end else begin
      state_r <= state_nxt;
    end
  end

  // outputs are plain flop bits, no logic after the register
  assign regRdData = state_r.rdData;
  assign regRdValid = state_r.rdValid;
  assign switchFreqSelect = freqField(state_r.switchCfg); // R01
  assign gateDriveStrength = twoBitField(state_r.switchCfg, GATE_DRIVE_LSB); // R05
  assign pulldownCurrentCode = state_r.pdCode; // R03
  assign loadPulldownOn = state_r.loadOn; // R02
  assign dischargeOn = state_r.discharge; // R04

  assign highQuiescent = bitAt(state_r.activeVolt, QUIESCENT_SEL_BIT); // R06
  assign activeVoltageCode = voltField(state_r.activeVolt); // R07
  assign outputVoltageCode = voltField(state_r.altVolt); // R08
  assign converterEnable = state_r.convOn; // R09
  assign peakLimitHigh = bitAt(state_r.modeCtrl, PEAK_LIMIT_BIT); // R13
  assign forceContinuousConduction = bitAt(state_r.modeCtrl, FORCE_CCM_BIT); // R14
  // exposed so the sequencer can see it; software is expected not to touch it
  assign factorySequenceBit = bitAt(state_r.modeCtrl, FACTORY_SEQ_BIT); // R16

endmodule : buck_regulator_config_regs

/* testbench/buck_regs_asserts.sv */
`timescale 1ns/100ps
module buck_regs_asserts
  import buck_regs_pkg::*;
(
  input wire logic ref_clk, rst, regWrEn, regRdEn, regRdValid, sleepMode,
  input wire logic converterEnable, dischargeOn, loadPulldownOn, highQuiescent,
  input wire logic [7:0] regAddr, regWrData, regRdData,
  input wire logic [4:0] activeVoltageCode,
  input wire switch_freq_t switchFreqSelect
);
  default clocking @(posedge ref_clk); endclocking
  default disable iff (rst);
  wire mapped = regAddr inside {[8'h81:8'h84]};
  a_read_answered: assert property (regRdEn |=> regRdValid)
    else $error("read not answered");
  a_unmapped_zero: assert property (regRdEn && !mapped |=> regRdData == 8'h00)
    else $error("unmapped read not zero");
  a_active_write: assert property (regWrEn && regAddr == ACTIVE_VOLT_ADDR |=>
    activeVoltageCode == $past(regWrData[4:0]) && highQuiescent == $past(regWrData[7]))
    else $error("active setpoint not written");
  a_freq_write: assert property (regWrEn && regAddr == SWITCH_CFG_ADDR |=>
    switchFreqSelect == $past(regWrData[7:6])) else $error("frequency not written");
  a_rsvd_active: assert property (regRdEn && regAddr == ACTIVE_VOLT_ADDR |=>
    regRdData[6:5] == 2'h0) else $error("reserved active bits not zero");
  a_rsvd_alt: assert property (regRdEn && regAddr == ALT_VOLT_ADDR |=>
    regRdData[7:5] == 3'h0) else $error("reserved alternate bits not zero");
  a_setpoint_held: assert property (!(regWrEn && regAddr == ACTIVE_VOLT_ADDR) |=>
    $stable(activeVoltageCode)) else $error("setpoint moved without write");
  a_load_discharge: assert property (!(dischargeOn && converterEnable) &&
    !(loadPulldownOn && !converterEnable)) else $error("load or discharge wrong state");
  a_sleep_off: assert property (regWrEn && regAddr == MODE_CTRL_ADDR && regWrData[4]
    ##1 sleepMode && !regWrEn |=> !converterEnable) else $error("on during sleep");
  a_override_on: assert property (regWrEn && regAddr == MODE_CTRL_ADDR &&
    (regWrData & 8'h94) == 8'h80 ##1 !regWrEn |=> converterEnable)
    else $error("override did not enable");
  c_unmapped: cover property (regRdEn && !mapped);
  c_sleep_gate: cover property (sleepMode && !converterEnable);
  c_alt_write: cover property (regWrEn && regAddr == ALT_VOLT_ADDR);
endmodule : buck_regs_asserts
bind buck_regulator_config_regs buck_regs_asserts buck_regs_asserts_inst (
  .ref_clk(ref_clk), .rst(rst), .regWrEn(regWrEn), .regRdEn(regRdEn),
  .regRdValid(regRdValid), .sleepMode(sleepMode), .converterEnable(converterEnable),
  .dischargeOn(dischargeOn), .loadPulldownOn(loadPulldownOn),
  .highQuiescent(highQuiescent), .regAddr(regAddr), .regWrData(regWrData),
  .regRdData(regRdData), .activeVoltageCode(activeVoltageCode),
  .switchFreqSelect(switchFreqSelect));

/* testbench/buck_regulator_config_regs_test.sv */
`timescale 1ns/100ps
module buck_regulator_config_regs_test;
  import buck_regs_pkg::*;
  logic ref_clk = 0, rst = 1, regWrEn = 0, regRdEn = 0, seqEnable = 0, sleepMode = 0;
  logic deepSleepMode = 0, regRdValid, loadPulldownOn, dischargeOn, highQuiescent;
  logic converterEnable, peakLimitHigh, forceContinuousConduction, factorySequenceBit;
  logic [7:0] regAddr = 8'h00, regWrData = 8'h00, regRdData;
  logic [1:0] pulldownCodeHigh = 2'h0, gateDriveStrength;
  logic [3:0] pulldownCurrentCode;
  logic [4:0] activeVoltageCode, outputVoltageCode;
  switch_freq_t switchFreqSelect;
  int failCount = 0, comparisons = 0;
  buck_regulator_config_regs buck_regulator_config_regs_inst (
    .ref_clk(ref_clk), .rst(rst), .regAddr(regAddr), .regWrData(regWrData),
    .regWrEn(regWrEn), .regRdEn(regRdEn), .regRdData(regRdData), .regRdValid(regRdValid),
    .pulldownCodeHigh(pulldownCodeHigh), .seqEnable(seqEnable), .sleepMode(sleepMode),
    .deepSleepMode(deepSleepMode), .switchFreqSelect(switchFreqSelect),
    .gateDriveStrength(gateDriveStrength), .pulldownCurrentCode(pulldownCurrentCode),
    .loadPulldownOn(loadPulldownOn), .dischargeOn(dischargeOn),
    .highQuiescent(highQuiescent), .activeVoltageCode(activeVoltageCode),
    .outputVoltageCode(outputVoltageCode), .converterEnable(converterEnable),
    .peakLimitHigh(peakLimitHigh), .forceContinuousConduction(forceContinuousConduction),
    .factorySequenceBit(factorySequenceBit));
  initial forever #4 ref_clk = ~ref_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : tick
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    comparisons++;
    if (g !== e) begin
      failCount++;
      $display("BAD %s expected %h seen %h", n, e, g);
    end
  endtask : chk
  // strobe dropped a full cycle before the next access, never re-driven in one step
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    regAddr = a;
    regWrData = d;
    regWrEn = 1'b1;
    tick(1);
    regWrEn = 1'b0;
    tick(1);
  endtask : wr
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    regAddr = a;
    regRdEn = 1'b1;
    tick(1);
    regRdEn = 1'b0;
    chk("rdvalid", 8'h01, {7'h0, regRdValid});
    chk("rddata", e, regRdData);
    tick(1);
  endtask : rd
  task automatic reset_values;
    rd(SWITCH_CFG_ADDR, 8'h40);
    rd(ACTIVE_VOLT_ADDR, 8'h8d);
    rd(ALT_VOLT_ADDR, 8'h07);
    rd(MODE_CTRL_ADDR, 8'h42);
    chk("freq", 8'h01, {6'h0, switchFreqSelect});
  endtask : reset_values
  task automatic reserved_writes;
    wr(ACTIVE_VOLT_ADDR, 8'hff);
    rd(ACTIVE_VOLT_ADDR, 8'h9f);
    chk("iq", 8'h01, {7'h0, highQuiescent});
    chk("vact", 8'h1f, {3'h0, activeVoltageCode});
    wr(ACTIVE_VOLT_ADDR, 8'h0d);
    chk("iq", 8'h00, {7'h0, highQuiescent});
    chk("vact", 8'h0d, {3'h0, activeVoltageCode});
    wr(ALT_VOLT_ADDR, 8'he5);
    rd(ALT_VOLT_ADDR, 8'h05);
    chk("converter_output", 8'h05, {3'h0, outputVoltageCode});
    wr(8'h85, 8'h55);
    rd(8'h85, 8'h00);
    rd(8'h80, 8'h00);
  endtask : reserved_writes
  task automatic switch_fields;
    for (int i = 0; i < 4; i++) begin
      wr(SWITCH_CFG_ADDR, {i[1:0], 4'h0, i[1:0]});
      chk("freq", i[7:0], {6'h0, switchFreqSelect});
      chk("drive", i[7:0], {6'h0, gateDriveStrength});
    end
    pulldownCodeHigh = 2'h3;
    wr(SWITCH_CFG_ADDR, 8'h24);
    chk("pdcode", 8'h0d, {4'h0, pulldownCurrentCode});
    chk("dis", 8'h01, {7'h0, dischargeOn});
    seqEnable = 1'b1;
    tick(2);
    chk("load", 8'h01, {7'h0, loadPulldownOn});
    wr(SWITCH_CFG_ADDR, 8'h10);
    seqEnable = 1'b0;
    tick(2);
    chk("dis", 8'h00, {7'h0, dischargeOn});
  endtask : switch_fields
  task automatic mode_control;
    wr(MODE_CTRL_ADDR, 8'h60);
    chk("force_continuous_conduction", 8'h00, {7'h0, forceContinuousConduction});
    seqEnable = 1'b1;
    tick(2);
    seqEnable = 1'b0;
    tick(2);
    chk("held", 8'h01, {7'h0, converterEnable});
    wr(MODE_CTRL_ADDR, 8'h40);
    tick(2);
    chk("release", 8'h00, {7'h0, converterEnable});
    chk("ilim", 8'h00, {7'h0, peakLimitHigh});
    wr(MODE_CTRL_ADDR, 8'hc1);
    chk("override", 8'h01, {7'h0, converterEnable});
    chk("force_continuous_conduction", 8'h01, {7'h0, forceContinuousConduction});
    sleepMode = 1'b1;
    wr(MODE_CTRL_ADDR, 8'hd0);
    chk("sleep", 8'h00, {7'h0, converterEnable});
    deepSleepMode = 1'b1;
    wr(MODE_CTRL_ADDR, 8'hc6);
    chk("deep", 8'h00, {7'h0, converterEnable});
    chk("ilim", 8'h01, {7'h0, peakLimitHigh});
    wr(MODE_CTRL_ADDR, 8'hc2);
    chk("stayon", 8'h01, {7'h0, converterEnable});
    chk("factory", 8'h01, {7'h0, factorySequenceBit});
  endtask : mode_control
  task automatic completeRun;
    $display("comparisons %0d mismatches %0d", comparisons, failCount);
    if (failCount == 0 && comparisons > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask : completeRun
  initial begin
    tick(16);
    rst = 1'b0;
    tick(1);
    reset_values();
    reserved_writes();
    switch_fields();
    mode_control();
    completeRun();
  end
endmodule : buck_regulator_config_regs_test
